/* core/btcb_branch_unit.v */
/*
 branch decision for bit-test, carry and compare-jump instructions.
 assumes the decoder gives one-cycle exec pulses with operands already fetched;
 bit_value is the addressed bit's current value (carry value when address is carry).
 the core builds pc_seq from length_reg of the fetched instruction, stores the
 carry flag when carry_we_reg pulses and writes zero to the mapped bit when
 bit_clr_reg pulses; every answer appears one clock after exec.
*/
`timescale 1ns/1ps
`include "btcb_defines.vh"
// Behaviour
// - bit-set branch jumps to target only when the addressed bit is one.
// - set-then-clear branch jumps and clears the bit only when it is one.
// - bit-clear branch jumps only when the addressed bit is zero.
// - carry-set branch tests only carry, no bit address, jumps if one.
// - carry branch is two bytes; bit branch on carry is three; both accepted.
// - carry-clear branch jumps only when carry is zero.
// - compare-jump jumps to its third operand when both operands differ.
// - equal compare operands fall through to the next instruction.
// - compare accepts acc/imm, acc/direct, register/imm, indirect/imm pairs.
// - compare always updates carry, whether the branch is taken or not.
// - carry becomes one when first operand is below second.
// - carry becomes zero when first operand is greater or equal.
// - bit addresses cover 128 user RAM bits and SFR bits above.
module btcb_branch_unit (
	input wire clk,
	input wire resetn,
	input wire exec,
	input wire [2:0] op_kind,
	input wire [15:0] pc_seq,
	input wire [15:0] target,
	input wire [7:0] bit_addr,
	input wire bit_value,
	input wire [1:0] cmp_form,
	input wire [7:0] acc,
	input wire [7:0] dir_byte,
	input wire [7:0] reg_byte,
	input wire [7:0] ind_byte,
	input wire [7:0] imm_byte,
	input wire carry_in,
	output reg [15:0] pc_reg,
	output reg pc_load_reg,
	output reg branch_taken_reg,
	output reg [1:0] length_reg,
	output reg carry_reg,
	output reg carry_we_reg,
	output reg bit_clr_reg,
	output reg [7:0] bit_byte_addr_reg,
	output reg [2:0] bit_lane_reg,
	output reg bit_is_sfr_reg,
	output reg bad_op_reg
);
	wire [7:0] map_byte;
	wire [2:0] map_lane;
	wire map_sfr;
	reg take;
	reg [7:0] lhs;
	reg [7:0] rhs;
	reg clr_next;
	reg cwe_next;
	reg c_next;
	reg [1:0] len_next;
	reg bad_next;
	// per-bit compare terms
	wire [7:0] bit_lt;
	wire [7:0] bit_eq;
	wire [8:0] borrow;
	wire [7:0] diff;
	wire cmp_less;
	wire cmp_differ;
	reg [15:0] pc_next;
	reg pc_load_next;
	reg taken_next;
	reg [1:0] length_next;
	reg carry_next;
	reg carry_we_next;
	reg bit_clr_next;
	reg [7:0] byte_addr_next;
	reg [2:0] lane_next;
	reg sfr_next;
	reg bad_op_next;
	genvar i;
	btcb_bit_map u_map (
		.bit_addr(bit_addr),
		.byte_addr(map_byte),
		.bit_lane(map_lane),
		.is_sfr(map_sfr)
	);
	// operand select apart from the decision, so the borrow chain forms no loop
	always @* begin
		lhs = acc;
		rhs = imm_byte;
		case (cmp_form)
			`BTCB_CMP_ACC_IMM: begin
				lhs = acc;
				rhs = imm_byte;
			end
			`BTCB_CMP_ACC_DIR: begin
				lhs = acc;
				rhs = dir_byte;
			end
			`BTCB_CMP_REG_IMM: begin
				lhs = reg_byte;
				rhs = imm_byte;
			end
			`BTCB_CMP_IND_IMM: begin
				lhs = ind_byte;
				rhs = imm_byte;
			end
			default: begin
				lhs = acc;
				rhs = imm_byte;
			end
		endcase
	end
	// subtract-style borrow chain; its borrow out is the compare's carry
	assign borrow[0] = 1'b0;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_cmp_bit
			assign bit_lt[i] = ~lhs[i] & rhs[i];
			assign bit_eq[i] = ~(lhs[i] ^ rhs[i]);
			assign diff[i] = ~bit_eq[i] ^ borrow[i];
			assign borrow[i + 1] = bit_lt[i] | (bit_eq[i] & borrow[i]);
		end
	endgenerate
	assign cmp_less = borrow[8]; // unsigned
	assign cmp_differ = |diff;
	always @* begin
		take = 1'b0;
		clr_next = 1'b0;
		cwe_next = 1'b0;
		c_next = carry_in;
		len_next = `BTCB_LEN_BIT;
		bad_next = 1'b0;
		case (op_kind)
			// bit_value carries the carry flag when bit_addr names it
			`BTCB_OP_BIT_SET: begin
				take = bit_value;
			end
			`BTCB_OP_SET_CLEAR: begin
				take = bit_value;
				clr_next = bit_value;
			end
			`BTCB_OP_BIT_CLEAR: begin
				take = ~bit_value;
			end
			`BTCB_OP_CARRY_SET: begin
				take = carry_in;
				len_next = `BTCB_LEN_CARRY;
			end
			`BTCB_OP_CARRY_CLEAR: begin
				take = ~carry_in;
				len_next = `BTCB_LEN_CARRY;
			end
			`BTCB_OP_COMPARE: begin
				take = cmp_differ;
				cwe_next = 1'b1;
				c_next = cmp_less;
			end
			`BTCB_OP_NONE: begin
				take = 1'b0;
			end
			default: begin
				// unknown kinds only flag bad_op; the pc still falls through
				bad_next = 1'b1;
			end
		endcase
	end
	// strobes drop after one cycle; held values stay for the core until the next exec
	always @* begin
		pc_next = pc_reg;
		pc_load_next = exec;
		taken_next = branch_taken_reg;
		length_next = length_reg;
		carry_next = carry_reg;
		carry_we_next = exec & cwe_next;
		bit_clr_next = exec & clr_next;
		byte_addr_next = bit_byte_addr_reg;
		lane_next = bit_lane_reg;
		sfr_next = bit_is_sfr_reg;
		bad_op_next = exec & bad_next;
		if (exec) begin
			pc_next = take ? target : pc_seq;
			taken_next = take;
			length_next = len_next;
			carry_next = c_next;
			byte_addr_next = map_byte;
			lane_next = map_lane;
			sfr_next = map_sfr;
		end
	end
	always @(posedge clk) begin
		if (!resetn) begin
			// reset wins over an exec in the same cycle
			pc_reg <= `BTCB_RESET_PC;
			pc_load_reg <= 1'b0;
			branch_taken_reg <= 1'b0;
			length_reg <= 2'h0;
			carry_reg <= 1'b0;
			carry_we_reg <= 1'b0;
			bit_clr_reg <= 1'b0;
			bit_byte_addr_reg <= 8'h00;
			bit_lane_reg <= 3'h0;
			bit_is_sfr_reg <= 1'b0;
			bad_op_reg <= 1'b0;
		end else begin
			pc_reg <= pc_next;
			pc_load_reg <= pc_load_next;
			branch_taken_reg <= taken_next;
			length_reg <= length_next;
			carry_reg <= carry_next;
			carry_we_reg <= carry_we_next;
			bit_clr_reg <= bit_clr_next;
			bit_byte_addr_reg <= byte_addr_next;
			bit_lane_reg <= lane_next;
			bit_is_sfr_reg <= sfr_next;
			bad_op_reg <= bad_op_next;
		end
	end
endmodule // btcb_branch_unit

/* core/btcb_defines.vh */
/*
 bit-test and compare branch unit constants: opcodes, operand selects, bit map.
 assumes inclusion by core files only.
*/
`ifndef BTCB_DEFINES_VH
`define BTCB_DEFINES_VH
// instruction kinds presented by the decoder
`define BTCB_OP_NONE 3'h0
`define BTCB_OP_BIT_SET 3'h1
`define BTCB_OP_SET_CLEAR 3'h2
`define BTCB_OP_BIT_CLEAR 3'h3
`define BTCB_OP_CARRY_SET 3'h4
`define BTCB_OP_CARRY_CLEAR 3'h5
`define BTCB_OP_COMPARE 3'h6
// compare operand pair forms
`define BTCB_CMP_ACC_IMM 2'h0
`define BTCB_CMP_ACC_DIR 2'h1
`define BTCB_CMP_REG_IMM 2'h2
`define BTCB_CMP_IND_IMM 2'h3
// program memory lengths
`define BTCB_LEN_CARRY 2'h2
`define BTCB_LEN_BIT 2'h3
// bit map
`define BTCB_BIT_SFR_POS 7
`define BTCB_USER_BYTE_BASE 8'h20
`define BTCB_CARRY_BIT_ADDR 8'hd7
`define BTCB_RESET_PC 16'h0000
`endif

/* core/btcb_bit_map.v */
/*
 bit address to byte address and bit lane.
 assumes 8-bit bit addresses; purely combinational.
*/
`timescale 1ns/1ps
`include "btcb_defines.vh"
module btcb_bit_map (
	input wire [7:0] bit_addr,
	output reg [7:0] byte_addr,
	output reg [2:0] bit_lane,
	output reg is_sfr
);
	always @* begin
		bit_lane = bit_addr[2:0];
		is_sfr = bit_addr[`BTCB_BIT_SFR_POS];
		if (is_sfr) begin
			byte_addr = {bit_addr[7:3], 3'h0};
		end else begin
			byte_addr = `BTCB_USER_BYTE_BASE + {4'h0, bit_addr[6:3]};
		end
	end
endmodule // btcb_bit_map

/* dv/btcb_monitor.sv */
/* assertions on the branch unit ports
 assumes one clock, synchronous active-low reset */
`timescale 1ns/1ps
module btcb_monitor (
	input wire clk,
	input wire resetn,
	input wire exec,
	input wire bit_value,
	input wire carry_in,
	input wire branch_taken_reg,
	input wire pc_load_reg,
	input wire carry_reg,
	input wire carry_we_reg,
	input wire bit_clr_reg,
	input wire [2:0] op_kind,
	input wire [1:0] cmp_form,
	input wire [1:0] length_reg,
	input wire [15:0] pc_seq,
	input wire [15:0] target,
	input wire [15:0] pc_reg,
	input wire [7:0] acc,
	input wire [7:0] imm_byte
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// idle cycles read as op none
	wire [2:0] k = exec ? op_kind : 3'h0;
	wire ai = k == 3'h6 && cmp_form == 2'h0;
	a_bit_set: assert property (k == 3'h1 |=>
		pc_reg == ($past(bit_value) ? $past(target) : $past(pc_seq))) else $error("bad pc");
	a_set_clear: assert property (k == 3'h2 |=> bit_clr_reg == $past(bit_value))
		else $error("bad clear");
	a_bit_clear: assert property (k == 3'h3 |=> branch_taken_reg != $past(bit_value))
		else $error("bad taken");
	a_carry_set: assert property (k == 3'h4 |=>
		branch_taken_reg == $past(carry_in) && length_reg == 2'h2) else $error("bad carry-set branch");
	a_carry_clear: assert property (k == 3'h5 |=> branch_taken_reg != $past(carry_in))
		else $error("bad carry-clear branch");
	a_cmp_carry: assert property (ai |=> carry_we_reg &&
		carry_reg == ($past(acc) < $past(imm_byte))) else $error("bad carry");
	a_cmp_jump: assert property (ai |=>
		branch_taken_reg == ($past(acc) != $past(imm_byte))) else $error("bad compare");
	a_bit_keep: assert property (k > 3'h0 && k < 3'h6 |=> !carry_we_reg)
		else $error("bad carry write");
	c_clear: cover property (bit_clr_reg);
	c_less: cover property (carry_we_reg && carry_reg);
	c_taken: cover property (pc_load_reg && branch_taken_reg);
	c_equal: cover property (carry_we_reg && !branch_taken_reg);
endmodule // btcb_monitor
bind btcb_branch_unit btcb_monitor u_mon (.clk, .resetn, .exec, .bit_value, .carry_in,
	.branch_taken_reg, .pc_load_reg, .carry_reg, .carry_we_reg, .bit_clr_reg, .op_kind,
	.cmp_form, .length_reg, .pc_seq, .target, .pc_reg, .acc, .imm_byte);

/* dv/test_btcb_branch_unit.sv */
/* self-checking bench: table rows, then back-to-back and illegal op
 assumes 125 MHz clk and synchronous active-low reset */
`timescale 1ns/1ps
module test_btcb_branch_unit;
	logic clk = 0, resetn = 0, exec = 0, bit_value = 0, carry_in = 0;
	logic [2:0] op_kind = 0;
	logic [1:0] cmp_form = 0;
	logic [15:0] pc_seq = 0, target = 0;
	logic [7:0] bit_addr = 0, acc = 0, dir_byte = 0, reg_byte = 0, ind_byte = 0, imm_byte = 0;
	wire [15:0] pc_reg;
	wire pc_load_reg, branch_taken_reg, carry_reg, carry_we_reg, bit_clr_reg, bit_is_sfr_reg;
	wire bad_op_reg;
	wire [1:0] length_reg;
	wire [7:0] bit_byte_addr_reg;
	wire [2:0] bit_lane_reg;
	int error_cnt = 0, n_tests = 0;
	logic [47:0] r;
	// nibbles: op, form, bit, carry, a, b, bit address, taken, new carry
	logic [47:0] rows [14] = '{48'h101100004011, 48'h100000008500, 48'h201000004510,
		48'h200100007f01, 48'h300000005010, 48'h30110000d701, 48'h400100000011,
		48'h400000000000, 48'h500100000001, 48'h500000000010, 48'h600010200011,
		48'h610140400000, 48'h6200807f0010, 48'h6301ff000010};
	btcb_branch_unit DUT (.clk, .resetn, .exec, .op_kind, .pc_seq, .target, .bit_addr,
		.bit_value, .cmp_form, .acc, .dir_byte, .reg_byte, .ind_byte, .imm_byte, .carry_in,
		.pc_reg, .pc_load_reg, .branch_taken_reg, .length_reg, .carry_reg, .carry_we_reg,
		.bit_clr_reg, .bit_byte_addr_reg, .bit_lane_reg, .bit_is_sfr_reg, .bad_op_reg);
	always #4 clk = ~clk;
	task chk(input logic [17:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task print_verdict;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// unused operand sources get the inverse, so a wrong select shows
	task issue(input logic [47:0] x);
		exec <= 1;
		{op_kind, cmp_form, bit_value, carry_in} <= {x[46:44], x[41:40], x[36], x[32]};
		acc <= x[41] ? ~x[31:24] : x[31:24];
		reg_byte <= x[41:40] == 2 ? x[31:24] : ~x[31:24];
		ind_byte <= x[41:40] == 3 ? x[31:24] : ~x[31:24];
		dir_byte <= x[41:40] == 1 ? x[23:16] : ~x[23:16];
		imm_byte <= x[41:40] == 1 ? ~x[23:16] : x[23:16];
		{bit_addr, target, pc_seq} <= {x[15:8], 4'h4, x[11:0], 4'h0, x[11:0]};
	endtask
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({pc_load_reg, carry_reg, pc_reg}, 18'h00000);
		@(posedge clk);
		resetn <= 1;
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge clk);
			issue(r);
			@(posedge clk);
			exec <= 0;
			@(negedge clk);
			chk({pc_load_reg, pc_reg}, {2'h2, r[4], 2'h0, r[11:0]});
			chk(branch_taken_reg, r[4]);
			chk(carry_reg, r[0]);
			chk(carry_we_reg, r[46:44] == 6);
			chk(bit_clr_reg, r[46:44] == 2 && r[36]);
			chk(length_reg, r[46] && !r[45] ? 2'h2 : 2'h3);
			if (r[46:44] < 4) chk({bit_is_sfr_reg, bit_lane_reg, bit_byte_addr_reg},
				{r[15], r[10:8], r[15] ? {r[15:11], 3'h0} : 8'h20 + r[14:11]});
		end
		@(posedge clk);
		issue(rows[10]);
		@(posedge clk);
		issue(48'h600130300000);
		@(negedge clk);
		chk({carry_we_reg, carry_reg, pc_reg}, 18'h34011);
		@(posedge clk);
		issue(48'h700000000000);
		@(negedge clk);
		chk({carry_we_reg, carry_reg, pc_reg}, 18'h20000);
		@(posedge clk);
		exec <= 0;
		@(negedge clk);
		chk({bad_op_reg, carry_we_reg, bit_clr_reg}, 3'h4);
		chk({pc_load_reg, branch_taken_reg, pc_reg}, 18'h20000);
		// strobes must be gone one cycle later; then reset meets an exec
		@(posedge clk);
		issue(rows[0]);
		resetn <= 0;
		@(negedge clk);
		chk({bad_op_reg, pc_load_reg, carry_we_reg}, 3'h0);
		@(posedge clk);
		exec <= 0;
		@(negedge clk);
		chk({pc_load_reg, branch_taken_reg, pc_reg}, 18'h00000);
		chk(length_reg, 2'h0);
		@(posedge clk);
		resetn <= 1;
		issue(rows[2]);
		@(negedge clk);
		chk({pc_load_reg, length_reg}, 3'h0);
		@(posedge clk);
		exec <= 0;
		@(negedge clk);
		chk({pc_load_reg, bit_clr_reg, pc_reg}, 18'h34510);
		print_verdict;
	end
	initial begin
		#2000;
		error_cnt++;
		print_verdict;
	end
endmodule // test_btcb_branch_unit
